// *** common/pause_ctrl_pkg.sv ***
/*
  Constants, register map and carrier types for the pause and MAC-control
  frame classifier and pause header generator.
  Assumes a single clock domain and a plain register port with 32-bit data.
*/
package pause_ctrl_pkg;

  // ==========================================================================
  // Register bus and beat geometry
  // ==========================================================================
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int BEAT_W  = 256;
  localparam int NCFG    = 21;
  localparam int ACK_W   = 9;

  // Byte addresses of the configuration words and the status word; index is address / 4.
  localparam logic [ADDR_W-1:0] OFS_CTRL          = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RX_GC_ETYPE   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RX_GC_RANGE   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RX_PC_ETYPE   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_RX_PC_RANGE   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RX_GP         = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RX_PP         = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_RX_MCAST_LO   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_RX_MCAST_HI   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_RX_UCAST_LO   = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_RX_UCAST_HI   = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_TX_GP         = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_TX_GP_DEST_LO = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_TX_GP_DEST_HI = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_TX_GP_SRC_LO  = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_TX_GP_SRC_HI  = 8'h3c;
  localparam logic [ADDR_W-1:0] OFS_TX_PP         = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_TX_PP_DEST_LO = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_TX_PP_DEST_HI = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_TX_PP_SRC_LO  = 8'h4c;
  localparam logic [ADDR_W-1:0] OFS_TX_PP_SRC_HI  = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_STATUS        = 8'h54;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CTRL_WAIT_BIT = 0;
  localparam int CTRL_FWD_BIT  = 1;
  localparam int CLS_GC        = 0;
  localparam int CLS_PC        = 1;
  localparam int CLS_GP        = 2;
  localparam int CLS_PP        = 3;
  localparam int ACK_GLOBAL    = 8;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] DEF_ETYPE     = 16'h8808;
  localparam logic [15:0] DEF_OP_LOW    = 16'h0000;
  localparam logic [15:0] DEF_OP_HIGH   = 16'hffff;
  localparam logic [15:0] DEF_GP_OP     = 16'h0001;
  localparam logic [15:0] DEF_PP_OP     = 16'h0101;
  localparam logic [47:0] DEF_MCAST     = 48'h0180c2000001;
  localparam logic [47:0] DEF_UCAST     = 48'h000000000000;
  localparam logic [47:0] DEF_SRC       = 48'h000000000000;
  localparam logic        DEF_WAIT      = 1'b1;
  localparam logic        DEF_FWD       = 1'b0;
  localparam logic [15:0] ZERO16        = 16'h0000;

  localparam logic [NCFG-1:0][DATA_W-1:0] CFG_RESET = {
    ZERO16, DEF_SRC[47:32], DEF_SRC[31:0],
    ZERO16, DEF_MCAST[47:32], DEF_MCAST[31:0], DEF_ETYPE, DEF_PP_OP,
    ZERO16, DEF_SRC[47:32], DEF_SRC[31:0],
    ZERO16, DEF_MCAST[47:32], DEF_MCAST[31:0], DEF_ETYPE, DEF_GP_OP,
    ZERO16, DEF_UCAST[47:32], DEF_UCAST[31:0],
    ZERO16, DEF_MCAST[47:32], DEF_MCAST[31:0],
    DEF_ETYPE, DEF_PP_OP, DEF_ETYPE, DEF_GP_OP,
    DEF_OP_HIGH, DEF_OP_LOW, ZERO16, DEF_ETYPE,
    DEF_OP_HIGH, DEF_OP_LOW, ZERO16, DEF_ETYPE,
    30'h00000000, DEF_FWD, DEF_WAIT
  };

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic              valid;
    logic              sop;
    logic              eop;
    logic [BEAT_W-1:0] data;
  } beat_t;

  typedef struct packed {
    logic [47:0] dest;
    logic [47:0] source;
    logic [15:0] ethertype;
    logic [15:0] opcode;
  } pause_hdr_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wstrobe;
    logic              rstrobe;
  } reg_req_t;

  typedef struct packed {
    logic [NCFG-1:0][DATA_W-1:0] cfg;
    logic [DATA_W-1:0]           rdata;
    beat_t                       rx_out;
    logic                        drop_held;
    logic [ACK_W-1:0]            pause_req;
    logic [3:0]                  rx_class;
    logic [15:0]                 drop_count;
  } state_t;

endpackage : pause_ctrl_pkg

// *** rtl/pause_frame_classify_generate.sv ***
/*
  Pause and MAC-control frame classifier for the receive path and header
  field source for generated global and priority pause frames.
  Assumes beats are synchronous to mclk, the first beat of a frame carries
  the first 32 bytes with byte 0 in the top bits, and software holds the
  configuration stable while frames flow.
*/
// Functional notes
// RL1: Global control ethertype is configurable, reset 0x8808.
// RL2: Configurable multicast destination is accepted for pause processing, reset 01-80-C2-00-00-01.
// RL3: Priority control ethertype is configurable, reset 0x8808.
// RL4: Priority control opcode must be at or above a lower bound, reset zero.
// RL5: Priority control opcode must be at or below an upper bound, reset all ones.
// RL6: Global pause ethertype is configurable, reset 0x8808.
// RL7: Global pause opcode must equal configurable value, reset 0x0001.
// RL8: Priority pause ethertype is configurable, reset 0x8808.
// RL9: Priority pause opcode must equal configurable value, reset 0x0101.
// RL10: With acknowledge wait on, requests hold until the 9-bit acknowledge; off, it is ignored.
// RL11: With forwarding on, control frames pass to the user side.
// RL12: With forwarding off, the reset state, control frames are dropped.
// RL13: Generated global pause destination is configurable, reset 01-80-C2-00-00-01.
// RL14: Generated global pause source is configurable, reset zero.
// RL15: Generated global pause ethertype is configurable, reset 0x8808.
// RL16: Generated global pause opcode is configurable, reset 0x0001.
// RL17: Generated priority pause destination is configurable, reset 01-80-C2-00-00-01.
// RL18: Generated priority pause source is configurable, reset zero.
// RL19: Generated priority pause ethertype is configurable, reset 0x8808.
// RL20: Generated priority pause opcode is configurable, reset 0x0101.
// RL21: Configurable unicast destination is also accepted, reset zero.
// RL22: Global control opcode must be at or above a lower bound, reset zero.
// RL23: Global control opcode must be at or below an upper bound, reset all ones.
// RL24: A class needs destination, ethertype and opcode all matching together.
// RL25: All settings reset to defaults and are held until software rewrites them.
`timescale 1ns/1ps

module pause_frame_classify_generate (
  input  wire logic                                  mclk,
  input  wire logic                                  rst_b,
  input  wire pause_ctrl_pkg::reg_req_t              reg_req,
  output logic        [pause_ctrl_pkg::DATA_W-1:0]   reg_rdata,
  input  wire pause_ctrl_pkg::beat_t                 rx_in,
  output pause_ctrl_pkg::beat_t                      rx_out,
  output logic        [3:0]                          rx_class,
  output logic        [pause_ctrl_pkg::ACK_W-1:0]    rx_pause_req,
  input  wire logic   [pause_ctrl_pkg::ACK_W-1:0]    rx_pause_ack_in,
  output pause_ctrl_pkg::pause_hdr_t                 tx_global_pause_hdr,
  output pause_ctrl_pkg::pause_hdr_t                 tx_priority_pause_hdr
);
  import pause_ctrl_pkg::*;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [DATA_W-1:0] write_mask(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CTRL:          write_mask = 32'h00000003;
      OFS_RX_GC_ETYPE,
      OFS_RX_PC_ETYPE,
      OFS_RX_MCAST_HI,
      OFS_RX_UCAST_HI,
      OFS_TX_GP_DEST_HI,
      OFS_TX_GP_SRC_HI,
      OFS_TX_PP_DEST_HI,
      OFS_TX_PP_SRC_HI:  write_mask = 32'h0000ffff;
      default:           write_mask = 32'hffffffff;
    endcase
  endfunction : write_mask

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  function automatic logic [47:0] addr48(input logic [DATA_W-1:0] hi, input logic [DATA_W-1:0] lo);
    addr48 = {hi[15:0], lo};
  endfunction : addr48

  // ==========================================================================
  // State
  // ==========================================================================
  state_t state;
  state_t next_state;

  logic [NCFG-1:0][DATA_W-1:0] cfg;
  logic                        wait_ack;
  logic                        forward_ctrl;
  logic [15:0]                 rx_global_ctrl_ethertype;
  logic [15:0]                 rx_global_ctrl_opcode_low;
  logic [15:0]                 rx_global_ctrl_opcode_high;
  logic [15:0]                 rx_priority_ctrl_ethertype;
  logic [15:0]                 rx_priority_ctrl_opcode_low;
  logic [15:0]                 rx_priority_ctrl_opcode_high;
  logic [15:0]                 rx_global_pause_ethertype;
  logic [15:0]                 rx_global_pause_opcode;
  logic [15:0]                 rx_priority_pause_ethertype;
  logic [15:0]                 rx_priority_pause_opcode;
  logic [47:0]                 rx_pause_multicast_dest;
  logic [47:0]                 rx_pause_unicast_dest;

  assign cfg = state.cfg;

  // ==========================================================================
  // Configuration fields
  // ==========================================================================
  assign wait_ack                     = cfg[OFS_CTRL >> 2][CTRL_WAIT_BIT];
  assign forward_ctrl                 = cfg[OFS_CTRL >> 2][CTRL_FWD_BIT];
  assign rx_global_ctrl_ethertype     = cfg[OFS_RX_GC_ETYPE >> 2][15:0];
  assign rx_global_ctrl_opcode_low    = cfg[OFS_RX_GC_RANGE >> 2][15:0];
  assign rx_global_ctrl_opcode_high   = cfg[OFS_RX_GC_RANGE >> 2][31:16];
  assign rx_priority_ctrl_ethertype   = cfg[OFS_RX_PC_ETYPE >> 2][15:0];
  assign rx_priority_ctrl_opcode_low  = cfg[OFS_RX_PC_RANGE >> 2][15:0];
  assign rx_priority_ctrl_opcode_high = cfg[OFS_RX_PC_RANGE >> 2][31:16];
  assign rx_global_pause_ethertype    = cfg[OFS_RX_GP >> 2][31:16];
  assign rx_global_pause_opcode       = cfg[OFS_RX_GP >> 2][15:0];
  assign rx_priority_pause_ethertype  = cfg[OFS_RX_PP >> 2][31:16];
  assign rx_priority_pause_opcode     = cfg[OFS_RX_PP >> 2][15:0];
  assign rx_pause_multicast_dest      = addr48(cfg[OFS_RX_MCAST_HI >> 2], cfg[OFS_RX_MCAST_LO >> 2]);
  assign rx_pause_unicast_dest        = addr48(cfg[OFS_RX_UCAST_HI >> 2], cfg[OFS_RX_UCAST_LO >> 2]);

  // ==========================================================================
  // Transmit pause header fields
  // ==========================================================================
  assign tx_global_pause_hdr.dest        = addr48(cfg[OFS_TX_GP_DEST_HI >> 2], cfg[OFS_TX_GP_DEST_LO >> 2]); // RL13
  assign tx_global_pause_hdr.source      = addr48(cfg[OFS_TX_GP_SRC_HI >> 2], cfg[OFS_TX_GP_SRC_LO >> 2]); // RL14
  assign tx_global_pause_hdr.ethertype   = cfg[OFS_TX_GP >> 2][31:16]; // RL15
  assign tx_global_pause_hdr.opcode      = cfg[OFS_TX_GP >> 2][15:0]; // RL16
  assign tx_priority_pause_hdr.dest      = addr48(cfg[OFS_TX_PP_DEST_HI >> 2], cfg[OFS_TX_PP_DEST_LO >> 2]); // RL17
  assign tx_priority_pause_hdr.source    = addr48(cfg[OFS_TX_PP_SRC_HI >> 2], cfg[OFS_TX_PP_SRC_LO >> 2]); // RL18
  assign tx_priority_pause_hdr.ethertype = cfg[OFS_TX_PP >> 2][31:16]; // RL19
  assign tx_priority_pause_hdr.opcode    = cfg[OFS_TX_PP >> 2][15:0]; // RL20

  // ==========================================================================
  // Receive header fields and classification
  // ==========================================================================
  logic [47:0] frame_dest;
  logic [15:0] frame_etype;
  logic [15:0] frame_opcode;
  logic [7:0]  frame_enables;
  logic        dest_ok;
  logic [3:0]  hit;
  logic        is_sop;
  logic        drop_now;

  assign frame_dest    = rx_in.data[BEAT_W-1 -: 48];
  assign frame_etype   = rx_in.data[BEAT_W-97 -: 16];
  assign frame_opcode  = rx_in.data[BEAT_W-113 -: 16];
  assign frame_enables = rx_in.data[BEAT_W-137 -: 8];

  assign dest_ok = (frame_dest == rx_pause_multicast_dest) || (frame_dest == rx_pause_unicast_dest); // RL2 RL21

  // Every class demands the destination, ethertype and opcode together.
  assign hit[CLS_GC] = dest_ok && (frame_etype == rx_global_ctrl_ethertype) // RL1 RL24
                       && in_range(frame_opcode, rx_global_ctrl_opcode_low, rx_global_ctrl_opcode_high); // RL22 RL23
  assign hit[CLS_PC] = dest_ok && (frame_etype == rx_priority_ctrl_ethertype) // RL3 RL24
                       && in_range(frame_opcode, rx_priority_ctrl_opcode_low, rx_priority_ctrl_opcode_high); // RL4 RL5
  assign hit[CLS_GP] = dest_ok && (frame_etype == rx_global_pause_ethertype) // RL6 RL24
                       && (frame_opcode == rx_global_pause_opcode); // RL7
  assign hit[CLS_PP] = dest_ok && (frame_etype == rx_priority_pause_ethertype) // RL8 RL24
                       && (frame_opcode == rx_priority_pause_opcode); // RL9

  assign is_sop   = rx_in.valid && rx_in.sop;
  assign drop_now = is_sop ? ((|hit) && !forward_ctrl) : state.drop_held; // RL11 RL12

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic [ADDR_W-1:0]  idx;
    logic [DATA_W-1:0]  mask;
    logic [ACK_W-1:0]   set_req;
    logic [ACK_W-1:0]   held_req;
    idx        = reg_req.addr >> 2;
    mask       = write_mask(reg_req.addr);
    set_req    = '0;
    held_req   = '0;
    next_state = state;

    // Register writes; the status word and unmapped addresses are ignored.
    if (reg_req.wstrobe && (reg_req.addr[1:0] == 2'b00) && (idx < ADDR_W'(NCFG))) begin
      next_state.cfg[idx[4:0]] = reg_req.wdata & mask; // RL25
    end

    // Read data stand only in the cycle after the read strobe.
    next_state.rdata = '0;
    if (reg_req.rstrobe && (reg_req.addr[1:0] == 2'b00)) begin
      if (idx < ADDR_W'(NCFG)) begin
        next_state.rdata = state.cfg[idx[4:0]];
      end else if (reg_req.addr == OFS_STATUS) begin
        next_state.rdata = {state.drop_count, 3'b000, state.pause_req, state.rx_class};
      end
    end

    // Receive path: one beat of latency, dropped beats leave a gap.
    next_state.rx_out       = rx_in;
    next_state.rx_out.valid = rx_in.valid && !drop_now; // RL11 RL12
    if (rx_in.valid) begin
      if (rx_in.eop) begin
        next_state.drop_held = 1'b0;
      end else if (rx_in.sop) begin
        next_state.drop_held = drop_now;
      end
    end
    if (is_sop && drop_now) begin
      next_state.drop_count = state.drop_count + 16'h0001;
    end

    next_state.rx_class = is_sop ? hit : 4'h0;

    // Pause requests: global on the top bit, priority from the enable vector.
    if (is_sop && hit[CLS_GP]) begin
      set_req[ACK_GLOBAL] = 1'b1;
    end
    if (is_sop && hit[CLS_PP]) begin
      set_req[ACK_GLOBAL-1:0] = frame_enables;
    end
    // A new request wins over an acknowledge in the same cycle.
    if (wait_ack) begin
      held_req = state.pause_req & ~rx_pause_ack_in; // RL10
    end
    next_state.pause_req = set_req | held_req; // RL10
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state.cfg        <= CFG_RESET; // RL25
      state.rdata      <= '0;
      state.rx_out     <= '0;
      state.drop_held  <= 1'b0;
      state.pause_req  <= '0;
      state.rx_class   <= 4'h0;
      state.drop_count <= 16'h0000;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign reg_rdata    = state.rdata;
  assign rx_out       = state.rx_out;
  assign rx_class     = state.rx_class;
  assign rx_pause_req = state.pause_req;

endmodule : pause_frame_classify_generate

// *** test/pause_ctrl_asserts.sv ***
/*
  Checker for the pause classifier and header source ports.
  Assumes one clock domain and attachment by the bind at the foot of this file.
*/
`timescale 1ns/1ps

module pause_ctrl_asserts (
  input wire logic                                mclk,
  input wire logic                                rst_b,
  input wire pause_ctrl_pkg::reg_req_t            reg_req,
  input wire logic [pause_ctrl_pkg::DATA_W-1:0]   reg_rdata,
  input wire pause_ctrl_pkg::beat_t               rx_in,
  input wire pause_ctrl_pkg::beat_t               rx_out,
  input wire logic [3:0]                          rx_class,
  input wire logic [pause_ctrl_pkg::ACK_W-1:0]    rx_pause_req,
  input wire logic [pause_ctrl_pkg::ACK_W-1:0]    rx_pause_ack_in,
  input wire pause_ctrl_pkg::pause_hdr_t          tx_global_pause_hdr,
  input wire pause_ctrl_pkg::pause_hdr_t          tx_priority_pause_hdr
);
  import pause_ctrl_pkg::*;

  // ==========================================================================
  // Shadow of the control word, so the checks know the active modes.
  // ==========================================================================
  logic wait_on;
  logic fwd_on;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wait_on <= 1'b1;
      fwd_on  <= 1'b0;
    end else if (reg_req.wstrobe && reg_req.addr == OFS_CTRL) begin
      wait_on <= reg_req.wdata[CTRL_WAIT_BIT];
      fwd_on  <= reg_req.wdata[CTRL_FWD_BIT];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_sop;
    rx_in.valid && rx_in.sop;
  endsequence
  sequence s_drop;
    s_sop ##1 !rx_out.valid;
  endsequence

  chk_drop_class: assert property (s_drop |-> rx_class != 4'h0)
    else $error("dropped frame without a class hit");
  chk_fwd_drop: assert property ((!fwd_on && rx_in.valid && rx_in.sop) ##1 rx_class != 4'h0 |-> !rx_out.valid)
    else $error("control frame passed with forwarding off");
  chk_fwd_pass: assert property (fwd_on && rx_in.valid |=> rx_out.valid)
    else $error("beat dropped with forwarding on");
  chk_beat_copy: assert property (rx_in.valid |=> rx_out.data == $past(rx_in.data) && rx_out.eop == $past(rx_in.eop))
    else $error("receive beat not copied");
  chk_class_cause: assert property (rx_class != 4'h0 |-> $past(rx_in.valid && rx_in.sop))
    else $error("class pulse without a start beat");
  chk_gp_request: assert property (rx_class[CLS_GP] |-> rx_pause_req[ACK_GLOBAL])
    else $error("global pause hit without request");
  chk_pp_bits: assert property (s_sop ##1 rx_class[CLS_PP]
      |-> (rx_pause_req[7:0] & $past(rx_in.data[119:112])) == $past(rx_in.data[119:112]))
    else $error("priority request bits missing");
  chk_wait_hold: assert property (wait_on && rx_pause_req[ACK_GLOBAL] && !rx_pause_ack_in[ACK_GLOBAL]
      |=> rx_pause_req[ACK_GLOBAL])
    else $error("request released before acknowledge");
  chk_ack_clear: assert property (wait_on && rx_pause_req[ACK_GLOBAL] && rx_pause_ack_in[ACK_GLOBAL]
      && !(rx_in.valid && rx_in.sop) |=> !rx_pause_req[ACK_GLOBAL])
    else $error("request kept after acknowledge");
  chk_no_wait: assert property (!wait_on && !(rx_in.valid && rx_in.sop) |=> !rx_pause_req[ACK_GLOBAL])
    else $error("request held with acknowledge wait off");
  chk_rdata_idle: assert property (!reg_req.rstrobe |=> reg_rdata == '0)
    else $error("read data outside the read cycle");
  chk_hdr_stable: assert property (!reg_req.wstrobe |=> $stable(tx_global_pause_hdr) && $stable(tx_priority_pause_hdr))
    else $error("header changed without a write");
  chk_gp_fields: assert property (reg_req.wstrobe && reg_req.addr == OFS_TX_GP
      |=> tx_global_pause_hdr.ethertype == $past(reg_req.wdata[31:16])
      && tx_global_pause_hdr.opcode == $past(reg_req.wdata[15:0]))
    else $error("global pause header fields not updated");

endmodule : pause_ctrl_asserts

bind pause_frame_classify_generate pause_ctrl_asserts pause_ctrl_asserts_i (
  .mclk(mclk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata), .rx_in(rx_in),
  .rx_out(rx_out), .rx_class(rx_class), .rx_pause_req(rx_pause_req), .rx_pause_ack_in(rx_pause_ack_in),
  .tx_global_pause_hdr(tx_global_pause_hdr), .tx_priority_pause_hdr(tx_priority_pause_hdr));

// *** test/pause_user_model.sv ***
/*
  Model of the user logic that acknowledges receive pause requests.
  Assumes one clock; lag sets how many cycles pass before it answers.
*/
`timescale 1ns/1ps

module pause_user_model (
  input  wire logic                               mclk,
  input  wire logic                               rst_b,
  input  wire logic [3:0]                         lag,
  input  wire logic [pause_ctrl_pkg::ACK_W-1:0]   rx_pause_req,
  output logic      [pause_ctrl_pkg::ACK_W-1:0]   rx_pause_ack_in
);
  import pause_ctrl_pkg::*;
  logic [3:0] waited;

  // Pending bits are answered with a one-cycle level once lag cycles passed.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      waited          <= 4'h0;
      rx_pause_ack_in <= '0;
    end else if (rx_pause_req != '0 && rx_pause_ack_in == '0) begin
      waited          <= waited + 4'h1;
      rx_pause_ack_in <= (waited >= lag) ? rx_pause_req : '0;
    end else begin
      waited          <= 4'h0;
      rx_pause_ack_in <= '0;
    end
  end
endmodule : pause_user_model

// *** test/tb.sv ***
/*
  Self-checking bench for the pause classifier and header source.
  Assumes the checker is bound in and the user model answers requests.
*/
`timescale 1ns/1ps

module tb;
  import pause_ctrl_pkg::*;
  localparam logic [47:0] MC = 48'h0180c2000001;
  localparam logic [47:0] UC = 48'h0a1133445566;
  typedef struct {logic [47:0] d; logic [15:0] t; logic [15:0] o; logic [3:0] c;} row_t;

  logic              mclk;
  logic              rst_b;
  reg_req_t          reg_req;
  logic [DATA_W-1:0] reg_rdata;
  beat_t             rx_in;
  beat_t             rx_out;
  logic [3:0]        rx_class;
  logic [ACK_W-1:0]  rx_pause_req;
  logic [ACK_W-1:0]  rx_pause_ack_in;
  pause_hdr_t        gp_hdr;
  pause_hdr_t        pp_hdr;
  logic [3:0]        lag;
  int                num_errors = 0;
  int                total_checks = 0;
  int                cycles = 0;
  logic [31:0]       resets [21] = '{32'h1, 32'h8808, 32'hffff0000, 32'h8808, 32'hffff0000, 32'h88080001,
    32'h88080101, 32'hc2000001, 32'h180, 32'h0, 32'h0, 32'h88080001, 32'hc2000001, 32'h180, 32'h0, 32'h0,
    32'h88080101, 32'hc2000001, 32'h180, 32'h0, 32'h0};
  logic [31:0]       txw [5] = '{32'h90000002, 32'h44556677, 32'h2233, 32'h8899aabb, 32'hccdd};
  row_t              rows [11] = '{'{MC, 16'h8808, 16'h0001, 4'h5}, '{MC, 16'h8808, 16'h0101, 4'ha},
    '{MC, 16'h8808, 16'h0150, 4'h2}, '{MC, 16'h8808, 16'h0050, 4'h1}, '{MC, 16'h0800, 16'h0001, 4'h0},
    '{48'h0180c2000002, 16'h8808, 16'h0001, 4'h0}, '{UC, 16'h8808, 16'h0001, 4'h5},
    '{MC, 16'h8808, 16'h00ff, 4'h1}, '{MC, 16'h8808, 16'h0100, 4'h2}, '{MC, 16'h8808, 16'h01ff, 4'h2},
    '{MC, 16'h8808, 16'h0200, 4'h0}};

  pause_frame_classify_generate pause_frame_classify_generate_i (
    .mclk(mclk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata), .rx_in(rx_in), .rx_out(rx_out),
    .rx_class(rx_class), .rx_pause_req(rx_pause_req), .rx_pause_ack_in(rx_pause_ack_in),
    .tx_global_pause_hdr(gp_hdr), .tx_priority_pause_hdr(pp_hdr));
  pause_user_model pause_user_model_i (.mclk(mclk), .rst_b(rst_b), .lag(lag),
    .rx_pause_req(rx_pause_req), .rx_pause_ack_in(rx_pause_ack_in));

  // ==========================================================================
  // Clock, timeout and shared tasks
  // ==========================================================================
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic check(input logic [255:0] got, input logic [255:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_req <= '{addr: a, wdata: d, wstrobe: 1'b1, rstrobe: 1'b0};
    @(posedge mclk);
    reg_req.wstrobe <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_req <= '{addr: a, wdata: 32'h0, wstrobe: 1'b0, rstrobe: 1'b1};
    @(posedge mclk);
    reg_req.rstrobe <= 1'b0;
    #1 check(reg_rdata, e);
  endtask : reg_rd

  // Sends a frame of the given beat count; returns just after its last beat's outputs settle.
  task automatic send(input logic [47:0] d, input logic [15:0] t, input logic [15:0] o, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rx_in <= '{valid: 1'b1, sop: i == 0, eop: i == n - 1, data: {d, 48'h02aabbccddee, t, o, 16'h005a, 112'h0}};
    end
    @(posedge mclk);
    rx_in.valid <= 1'b0;
    #1;
  endtask : send

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst_b   = 1'b0;
    reg_req = '0;
    rx_in   = '0;
    lag     = 4'h6;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (resets[i]) reg_rd(8'(i * 4), resets[i]);
    check(gp_hdr, {MC, 48'h0, 16'h8808, 16'h0001});
    check(pp_hdr, {MC, 48'h0, 16'h8808, 16'h0101});
    reg_wr(8'h05, 32'h0);
    reg_wr(8'h54, 32'hffffffff);
    reg_rd(8'h04, 32'h8808);
    reg_rd(8'h58, 32'h0);
    reg_wr(8'h08, 32'h00ff0000);
    reg_wr(8'h10, 32'h01ff0100);
    reg_wr(8'h24, 32'h33445566);
    reg_wr(8'h28, 32'h00000a11);
    foreach (rows[i]) begin
      send(rows[i].d, rows[i].t, rows[i].o, 1);
      check(rx_class, rows[i].c);
      check(rx_out.valid, rows[i].c == 4'h0);
    end
    repeat (12) @(posedge mclk);
    reg_rd(8'h54, 32'h00080000);
    send(MC, 16'h8808, 16'h0001, 1);
    check(rx_pause_req, 9'h100);
    repeat (4) @(posedge mclk);
    #1 check(rx_pause_req[8], 1'b1);
    repeat (8) @(posedge mclk);
    #1 check(rx_pause_req[8], 1'b0);
    send(MC, 16'h8808, 16'h0101, 1);
    check(rx_pause_req[7:0], 8'h5a);
    repeat (12) @(posedge mclk);
    reg_wr(8'h00, 32'h0);
    lag <= 4'h0;
    send(MC, 16'h8808, 16'h0001, 1);
    check(rx_pause_req[8], 1'b1);
    @(posedge mclk);
    #1 check(rx_pause_req[8], 1'b0);
    reg_wr(8'h00, 32'h2);
    send(MC, 16'h8808, 16'h0001, 3);
    check({rx_out.valid, rx_out.eop}, 2'b11);
    reg_wr(8'h00, 32'h0);
    send(MC, 16'h8808, 16'h0001, 3);
    check(rx_out.valid, 1'b0);
    reg_wr(8'h04, 32'h8809);
    reg_wr(8'h0c, 32'h880a);
    reg_wr(8'h14, 32'h88090001);
    reg_wr(8'h18, 32'h880a0101);
    send(MC, 16'h8809, 16'h0001, 1);
    check(rx_class, 4'h5);
    send(MC, 16'h880a, 16'h0101, 1);
    check(rx_class, 4'ha);
    foreach (txw[i]) begin
      reg_wr(8'h2c + 8'(i * 4), txw[i]);
      reg_wr(8'h40 + 8'(i * 4), txw[i]);
    end
    #1 check(gp_hdr, {48'h223344556677, 48'hccdd8899aabb, 32'h90000002});
    check(pp_hdr, {48'h223344556677, 48'hccdd8899aabb, 32'h90000002});
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    #1 check(gp_hdr, {MC, 48'h0, 16'h8808, 16'h0001});
    reg_rd(8'h00, 32'h1);
    close_out();
  end
endmodule : tb
